// ===== hdl/crbse_ram_regs.vh
// Constants for the chained dual-port ECC memory block.
`ifndef CRBSE_RAM_REGS_VH
`define CRBSE_RAM_REGS_VH
`define CRBSE_ORDER_NONE 2'h0
`define CRBSE_ORDER_FIRST 2'h1
`define CRBSE_ORDER_MIDDLE 2'h2
`define CRBSE_ORDER_LAST 2'h3
`define CRBSE_MASK_DEFAULT 11'h7ff
`define CRBSE_SELF_DEFAULT 11'h000
`define CRBSE_SEL_HI 22
`define CRBSE_SEL_LO 12
`define CRBSE_ADDR_W 23
`define CRBSE_WADDR_W 12
`define CRBSE_DEPTH 4096
`define CRBSE_DATA_W 64
`define CRBSE_CHECK_W 8
`define CRBSE_WORD_W 72
`define CRBSE_MASK_W 9
`define CRBSE_INJ_BIT_LO 30
`define CRBSE_INJ_BIT_HI 62
`endif

// ===== hdl/crbse_ram.v
// Dual-port 4K x 72 memory block with chain select decode and ECC.
//
// How it works
// - Each port has a chain position: none, first, middle or last.
// - Select mask ones over address bits 22..12 mark ignored bits.
// - Block is hit when unmasked address bits equal its self-select value.
// - Requests enter at the first block; read data leaves at chain top.
// - Shared select values let one write reach several blocks at once.
// - With ECC on, the top eight word bits hold check bits, both ports.
// - Encoder computes eight check bits from 64 data bits on writes.
// - Decoder corrects single-bit errors and detects double-bit errors.
// - Single and double error flags per port encode three outcomes.
// - Correction reaches only the output; the stored word stays unchanged.
// - Optional output stages before and after the decoder, flags included.
// - Port reset clears that port's output registers and flags to zero.
// - Single injection inverts write data bit 30 in the stored word.
// - Double injection inverts write data bits 30 and 62.
// - Both injections together inject only the double error.
// - Injection works in full, encoder-only and decoder-only modes.
// - Full mode stores generated check bits, ignores external ones.
// - Encoder-only reads return the stored word without decoding.
// - Decoder-only stores the supplied word, reads are decoded.
// - All ECC data, status and control act on the single clock.
// - Chain exit output holds the last read data when no read occurs.
// - Decoder-only check bits come from write data bits 71..64.
`timescale 1ns/1ps
`include "crbse_ram_regs.vh"

module crbse_ram #(
    parameter [1:0] CHAIN_ORDER_A = `CRBSE_ORDER_NONE,
    parameter [1:0] CHAIN_ORDER_B = `CRBSE_ORDER_NONE,
    parameter [10:0] SELF_MASK_A = `CRBSE_MASK_DEFAULT,
    parameter [10:0] SELF_MASK_B = `CRBSE_MASK_DEFAULT,
    parameter [10:0] SELF_ADDR_A = `CRBSE_SELF_DEFAULT,
    parameter [10:0] SELF_ADDR_B = `CRBSE_SELF_DEFAULT,
    parameter ECC_ENC_A = 1,
    parameter ECC_ENC_B = 1,
    parameter ECC_DEC_A = 1,
    parameter ECC_DEC_B = 1,
    parameter OREG_A = 0,
    parameter OREG_B = 0,
    parameter OREG_ECC_A = 0,
    parameter OREG_ECC_B = 0
) (
    // Clock and resets
    input wire mclk,
    input wire rst_n,
    input wire a_rst_n,
    input wire b_rst_n,
    // Port A user request
    input wire [22:0] a_addr,
    input wire a_en,
    input wire a_we,
    input wire [71:0] a_din,
    input wire [8:0] a_byte_write_mask,
    input wire a_inject_single_error,
    input wire a_inject_double_error,
    // Port A user answer
    output wire [71:0] a_dout,
    output wire a_single_error_flag,
    output wire a_double_error_flag,
    output wire a_rd_access,
    // Port A cascade from the block below
    input wire [22:0] a_cas_in_addr,
    input wire a_cas_in_en,
    input wire a_cas_in_we,
    input wire [71:0] a_cas_in_din,
    input wire [8:0] a_cas_in_bwmask,
    input wire a_cas_in_inj_single,
    input wire a_cas_in_inj_double,
    input wire [71:0] a_cas_in_dout,
    input wire a_cas_in_serr,
    input wire a_cas_in_derr,
    input wire a_cas_in_rdacc,
    // Port A cascade to the block above
    output wire [22:0] a_cas_out_addr,
    output wire a_cas_out_en,
    output wire a_cas_out_we,
    output wire [71:0] a_cas_out_din,
    output wire [8:0] a_cas_out_bwmask,
    output wire a_cas_out_inj_single,
    output wire a_cas_out_inj_double,
    output wire [71:0] a_cas_out_dout,
    output wire a_cas_out_serr,
    output wire a_cas_out_derr,
    output wire a_cas_out_rdacc,
    // Port B user request
    input wire [22:0] b_addr,
    input wire b_en,
    input wire b_we,
    input wire [71:0] b_din,
    input wire [8:0] b_byte_write_mask,
    input wire b_inject_single_error,
    input wire b_inject_double_error,
    // Port B user answer
    output wire [71:0] b_dout,
    output wire b_single_error_flag,
    output wire b_double_error_flag,
    output wire b_rd_access,
    // Port B cascade from the block below
    input wire [22:0] b_cas_in_addr,
    input wire b_cas_in_en,
    input wire b_cas_in_we,
    input wire [71:0] b_cas_in_din,
    input wire [8:0] b_cas_in_bwmask,
    input wire b_cas_in_inj_single,
    input wire b_cas_in_inj_double,
    input wire [71:0] b_cas_in_dout,
    input wire b_cas_in_serr,
    input wire b_cas_in_derr,
    input wire b_cas_in_rdacc,
    // Port B cascade to the block above
    output wire [22:0] b_cas_out_addr,
    output wire b_cas_out_en,
    output wire b_cas_out_we,
    output wire [71:0] b_cas_out_din,
    output wire [8:0] b_cas_out_bwmask,
    output wire b_cas_out_inj_single,
    output wire b_cas_out_inj_double,
    output wire [71:0] b_cas_out_dout,
    output wire b_cas_out_serr,
    output wire b_cas_out_derr,
    output wire b_cas_out_rdacc
);

    // ****************************************************
    // Functions
    // ****************************************************

    // Hamming code over positions 1..71, data at non power-of-two
    // positions, bit 7 is the overall parity of the whole word.
    function [7:0] ecc_gen;
        input [63:0] d;
        integer p;
        integer k;
        integer i;
        reg [7:0] c;
        begin
            c = 8'h00;
            i = 0;
            for (p = 1; p < 72; p = p + 1) begin
                if ((p & (p - 1)) != 0) begin
                    for (k = 0; k < 7; k = k + 1) begin
                        if (((p >> k) & 1) == 1)
                            c[k] = c[k] ^ d[i];
                    end
                    i = i + 1;
                end
            end
            c[7] = ^{d, c[6:0]};
            ecc_gen = c;
        end
    endfunction

    // Returns {double, single, corrected word}.
    function [73:0] ecc_fix;
        input [71:0] w;
        reg [7:0] c;
        reg [6:0] s;
        reg [71:0] o;
        reg se;
        reg de;
        integer p;
        integer i;
        integer k;
        begin
            c = ecc_gen(w[63:0]);
            s = c[6:0] ^ w[70:64];
            o = w;
            se = 1'b0;
            de = 1'b0;
            i = 0;
            if (^w) begin
                if (s > 7'h47) begin
                    de = 1'b1;
                end else begin
                    se = 1'b1;
                    if (s == 7'h00)
                        o[71] = ~o[71];
                    for (k = 0; k < 7; k = k + 1) begin
                        if (s == (7'h01 << k))
                            o[64 + k] = ~o[64 + k];
                    end
                    for (p = 1; p < 72; p = p + 1) begin
                        if ((p & (p - 1)) != 0) begin
                            if (s == p)
                                o[i] = ~o[i];
                            i = i + 1;
                        end
                    end
                end
            end else if (s != 7'h00) begin
                de = 1'b1;
            end
            ecc_fix = {de, se, o};
        end
    endfunction

    // Merges a new word into the old one under the byte-write mask.
    function [71:0] merge;
        input [71:0] old;
        input [71:0] nw;
        input [8:0] m;
        integer b;
        reg [71:0] r;
        begin
            r = old;
            for (b = 0; b < 9; b = b + 1) begin
                if (m[b])
                    r[b * 8 +: 8] = nw[b * 8 +: 8];
            end
            merge = r;
        end
    endfunction

    // ****************************************************
    // Request selection and write word
    // ****************************************************

    reg [71:0] mem [0:`CRBSE_DEPTH - 1];

    wire [22:0] r_addr [0:1];
    wire r_en [0:1];
    wire r_we [0:1];
    wire [71:0] r_din [0:1];
    wire [8:0] r_bwm [0:1];
    wire r_injs [0:1];
    wire r_injd [0:1];
    wire [71:0] w_full [0:1];
    wire r_wr [0:1];
    wire r_rd [0:1];
    wire [71:0] c_dout [0:1];
    wire c_serr [0:1];
    wire c_derr [0:1];
    wire c_acc [0:1];
    wire prst [0:1];

    // Chain position picks user or cascade request.
    // position steers source
    wire a_chained = (CHAIN_ORDER_A == `CRBSE_ORDER_MIDDLE) ||
        (CHAIN_ORDER_A == `CRBSE_ORDER_LAST);
    wire b_chained = (CHAIN_ORDER_B == `CRBSE_ORDER_MIDDLE) ||
        (CHAIN_ORDER_B == `CRBSE_ORDER_LAST);
    // requests enter at the first block
    assign r_addr[0] = a_chained ? a_cas_in_addr : a_addr;
    assign r_en[0] = a_chained ? a_cas_in_en : a_en;
    assign r_we[0] = a_chained ? a_cas_in_we : a_we;
    assign r_din[0] = a_chained ? a_cas_in_din : a_din;
    assign r_bwm[0] = a_chained ? a_cas_in_bwmask : a_byte_write_mask;
    assign r_injs[0] = a_chained ? a_cas_in_inj_single :
        a_inject_single_error;
    assign r_injd[0] = a_chained ? a_cas_in_inj_double :
        a_inject_double_error;
    assign r_addr[1] = b_chained ? b_cas_in_addr : b_addr;
    assign r_en[1] = b_chained ? b_cas_in_en : b_en;
    assign r_we[1] = b_chained ? b_cas_in_we : b_we;
    assign r_din[1] = b_chained ? b_cas_in_din : b_din;
    assign r_bwm[1] = b_chained ? b_cas_in_bwmask : b_byte_write_mask;
    assign r_injs[1] = b_chained ? b_cas_in_inj_single :
        b_inject_single_error;
    assign r_injd[1] = b_chained ? b_cas_in_inj_double :
        b_inject_double_error;
    assign c_dout[0] = a_cas_in_dout;
    assign c_serr[0] = a_cas_in_serr;
    assign c_derr[0] = a_cas_in_derr;
    assign c_acc[0] = a_chained & a_cas_in_rdacc;
    assign c_dout[1] = b_cas_in_dout;
    assign c_serr[1] = b_cas_in_serr;
    assign c_derr[1] = b_cas_in_derr;
    assign c_acc[1] = b_chained & b_cas_in_rdacc;
    assign prst[0] = ~rst_n | ~a_rst_n;
    assign prst[1] = ~rst_n | ~b_rst_n;

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            localparam [1:0] ORD = p == 0 ? CHAIN_ORDER_A : CHAIN_ORDER_B;
            localparam [10:0] MSK = p == 0 ? SELF_MASK_A : SELF_MASK_B;
            localparam [10:0] SLF = p == 0 ? SELF_ADDR_A : SELF_ADDR_B;
            localparam ENC = p == 0 ? ECC_ENC_A : ECC_ENC_B;
            localparam DEC = p == 0 ? ECC_DEC_A : ECC_DEC_B;
            localparam OR1 = p == 0 ? OREG_A : OREG_B;
            localparam OR2 = p == 0 ? OREG_ECC_A : OREG_ECC_B;

            // surviving bits must match self value
            wire [10:0] sel =
                r_addr[p][`CRBSE_SEL_HI:`CRBSE_SEL_LO];
            wire hit = (ORD == `CRBSE_ORDER_NONE) ||
                ((sel | MSK) == (SLF | MSK));
            assign r_wr[p] = hit & r_en[p] & r_we[p];
            assign r_rd[p] = hit & r_en[p] & ~r_we[p];

            wire [71:0] enc_w = ENC ?
                {ecc_gen(r_din[p][63:0]), r_din[p][63:0]} : r_din[p];
            // double injection on bits 30 and 62
            wire [71:0] inj_w = enc_w ^
                ({71'h0, r_injs[p] | r_injd[p]} << `CRBSE_INJ_BIT_LO) ^
                ({71'h0, r_injd[p]} << `CRBSE_INJ_BIT_HI);
            assign w_full[p] = merge(mem[r_addr[p][11:0]], inj_w,
                r_bwm[p]);

            // ****************************************************
            // Read pipeline
            // ****************************************************

            reg [71:0] s0_w;
            reg s0_v;
            reg [71:0] s1_w;
            reg s1_v;
            reg [71:0] s2_w;
            reg s2_s;
            reg s2_d;
            reg s2_v;
            reg [71:0] dout_q;
            reg serr_q;
            reg derr_q;
            reg acc_q;

            // Port A executes first, so B sees A's write.
            wire [71:0] rd_w = (p == 1 && r_wr[0] &&
                r_addr[0][11:0] == r_addr[p][11:0]) ? w_full[0] :
                mem[r_addr[p][11:0]];

            always @(posedge mclk) begin
                if (prst[p]) begin
                    s0_w <= 72'h0;
                    s0_v <= 1'b0;
                    s1_w <= 72'h0;
                    s1_v <= 1'b0;
                end else begin
                    s0_v <= r_rd[p];
                    if (r_rd[p])
                        s0_w <= rd_w;
                    s1_v <= s0_v;
                    s1_w <= s0_w;
                end
            end

            wire [71:0] pre_w = OR1 ? s1_w : s0_w;
            wire pre_v = OR1 ? s1_v : s0_v;
            wire [73:0] fix = ecc_fix(pre_w);
            wire [71:0] dec_w = DEC ? fix[71:0] : pre_w;
            wire dec_s = DEC ? fix[72] : 1'b0;
            wire dec_d = DEC ? fix[73] : 1'b0;

            always @(posedge mclk) begin
                if (prst[p]) begin
                    s2_w <= 72'h0;
                    s2_s <= 1'b0;
                    s2_d <= 1'b0;
                    s2_v <= 1'b0;
                end else begin
                    s2_w <= dec_w;
                    s2_s <= dec_s & pre_v;
                    s2_d <= dec_d & pre_v;
                    s2_v <= pre_v;
                end
            end

            wire own_v = OR2 ? s2_v : pre_v;
            wire [71:0] own_w = OR2 ? s2_w : dec_w;
            wire own_s = OR2 ? s2_s : dec_s;
            wire own_d = OR2 ? s2_d : dec_d;

            wire [71:0] ch_w = own_v ? own_w : c_dout[p];
            wire ch_s = own_v ? own_s : c_serr[p];
            wire ch_d = own_v ? own_d : c_derr[p];
            wire ch_v = own_v | c_acc[p];

            always @(posedge mclk) begin
                if (prst[p]) begin
                    dout_q <= 72'h0;
                    serr_q <= 1'b0;
                    derr_q <= 1'b0;
                    acc_q <= 1'b0;
                end else begin
                    acc_q <= ch_v;
                    if (ch_v) begin
                        dout_q <= ch_w;
                        serr_q <= ch_s;
                        derr_q <= ch_d;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************
    // Array writes
    // ****************************************************

    // Port B is applied last and wins a same-address write.
    // check bits in the top byte
    always @(posedge mclk) begin
        if (r_wr[0])
            mem[r_addr[0][11:0]] <= w_full[0];
        if (r_wr[1])
            mem[r_addr[1][11:0]] <= w_full[1];
    end

    // ****************************************************
    // Outputs
    // ****************************************************

    assign a_dout = g_port[0].dout_q;
    assign a_single_error_flag = g_port[0].serr_q;
    assign a_double_error_flag = g_port[0].derr_q;
    assign a_rd_access = g_port[0].acc_q;
    assign b_dout = g_port[1].dout_q;
    assign b_single_error_flag = g_port[1].serr_q;
    assign b_double_error_flag = g_port[1].derr_q;
    assign b_rd_access = g_port[1].acc_q;

    // Cascade outputs run through so a whole column acts in one cycle.
    assign a_cas_out_addr = r_addr[0];
    assign a_cas_out_en = r_en[0];
    assign a_cas_out_we = r_we[0];
    assign a_cas_out_din = r_din[0];
    assign a_cas_out_bwmask = r_bwm[0];
    assign a_cas_out_inj_single = r_injs[0];
    assign a_cas_out_inj_double = r_injd[0];
    assign a_cas_out_dout = g_port[0].ch_w;
    assign a_cas_out_serr = g_port[0].ch_s;
    assign a_cas_out_derr = g_port[0].ch_d;
    assign a_cas_out_rdacc = g_port[0].ch_v;
    assign b_cas_out_addr = r_addr[1];
    assign b_cas_out_en = r_en[1];
    assign b_cas_out_we = r_we[1];
    assign b_cas_out_din = r_din[1];
    assign b_cas_out_bwmask = r_bwm[1];
    assign b_cas_out_inj_single = r_injs[1];
    assign b_cas_out_inj_double = r_injd[1];
    assign b_cas_out_dout = g_port[1].ch_w;
    assign b_cas_out_serr = g_port[1].ch_s;
    assign b_cas_out_derr = g_port[1].ch_d;
    assign b_cas_out_rdacc = g_port[1].ch_v;

endmodule

// ===== verification/crbse_ram_sva.sv
// Port checker for the chained ECC memory block.
`timescale 1ns/1ps
module crbse_ram_sva #(
    parameter [1:0] CHAIN_ORDER_A = 2'h0,
    parameter [10:0] SELF_MASK_A = 11'h7ff,
    parameter [10:0] SELF_ADDR_A = 11'h000,
    parameter ECC_DEC_B = 1
) (
    // Clock and resets
    input wire mclk,
    input wire rst_n,
    input wire a_rst_n,
    input wire b_rst_n,
    // Port A
    input wire [22:0] a_addr,
    input wire a_en,
    input wire a_we,
    input wire [71:0] a_din,
    input wire [71:0] a_dout,
    input wire a_single_error_flag,
    input wire a_double_error_flag,
    input wire a_rd_access,
    input wire [22:0] a_cas_out_addr,
    input wire a_cas_out_en,
    input wire [71:0] a_cas_out_din,
    input wire [71:0] a_cas_out_dout,
    input wire a_cas_out_rdacc,
    // Port B
    input wire b_en,
    input wire b_we,
    input wire b_single_error_flag,
    input wire b_double_error_flag,
    input wire b_rd_access
);
    // ****************************************
    // Read tracking and checks
    // ****************************************
    wire hit_a = (CHAIN_ORDER_A == 2'h0) ||
        ((a_addr[22:12] | SELF_MASK_A) == (SELF_ADDR_A | SELF_MASK_A));
    wire rd_a = a_en && !a_we && hit_a;
    wire [1:0] flags_a = {a_double_error_flag, a_single_error_flag};
    default clocking cb @(posedge mclk); endclocking
    sequence rd_req_a; rd_a; endsequence
    sequence rd_req_b; b_en && !b_we; endsequence
    sequence word_out_a; a_cas_out_rdacc ##1 a_rd_access; endsequence

    read_latency_a: assert property (
        disable iff (!rst_n || !a_rst_n) rd_req_a |-> ##1 word_out_a)
        else $error("port A read word missing two cycles after hit");
    read_cause_a: assert property (
        disable iff (!rst_n || !a_rst_n) a_rd_access |-> $past(rd_a, 2))
        else $error("port A read word without a hit request");
    read_latency_b: assert property (
        disable iff (!rst_n || !b_rst_n) rd_req_b |-> ##2 b_rd_access)
        else $error("port B read word missing two cycles after request");
    output_hold_a: assert property (
        disable iff (!rst_n || !a_rst_n)
        (!a_rd_access && $past(a_rst_n) && $past(rst_n)) |->
        ($stable(a_dout) && $stable(flags_a)))
        else $error("port A output changed without a read word");
    reset_clear_a: assert property (
        disable iff (!rst_n)
        !a_rst_n |=> (a_dout == 72'h0 && flags_a == 2'h0 && !a_rd_access))
        else $error("port A outputs not cleared by port reset");
    flag_exclusive_a: assert property (
        disable iff (!rst_n) flags_a != 2'h3)
        else $error("port A shows both error flags");
    dec_off_b: assert property (
        disable iff (!rst_n)
        (ECC_DEC_B != 0) || (!b_single_error_flag && !b_double_error_flag))
        else $error("port B error flag with decoder off");
    cascade_req_a: assert property (
        disable iff (!rst_n) (CHAIN_ORDER_A != 2'h1) ||
        (a_cas_out_addr == a_addr && a_cas_out_en == a_en &&
        a_cas_out_din == a_din))
        else $error("port A request not passed up the chain");
    cascade_read_a: assert property (
        disable iff (!rst_n) a_rd_access |-> a_dout == $past(a_cas_out_dout))
        else $error("port A read word not passed up the chain");
endmodule

bind crbse_ram crbse_ram_sva #(
    .CHAIN_ORDER_A(CHAIN_ORDER_A), .SELF_MASK_A(SELF_MASK_A),
    .SELF_ADDR_A(SELF_ADDR_A), .ECC_DEC_B(ECC_DEC_B)
) chk (
    .mclk, .rst_n, .a_rst_n, .b_rst_n, .a_addr, .a_en, .a_we, .a_din,
    .a_dout, .a_single_error_flag, .a_double_error_flag, .a_rd_access,
    .a_cas_out_addr, .a_cas_out_en, .a_cas_out_din, .a_cas_out_dout,
    .a_cas_out_rdacc, .b_en, .b_we, .b_single_error_flag,
    .b_double_error_flag, .b_rd_access
);

// ===== verification/crbse_user.sv
// Behavioural user fabric logic issuing requests on one memory port.
`timescale 1ns/1ps
module crbse_user (
    // Clock
    input wire mclk,
    // Request to the port
    output reg [22:0] addr,
    output reg en,
    output reg we,
    output reg [71:0] din,
    output reg [8:0] mask,
    output reg inj_s,
    output reg inj_d,
    // Answer from the port
    input wire [71:0] dout,
    input wire serr,
    input wire derr,
    input wire rdacc
);
    initial begin
        addr = 23'h0;
        en = 1'b0;
        we = 1'b0;
        din = 72'h0;
        mask = 9'h1ff;
        {inj_d, inj_s} = 2'h0;
    end

    // ****************************************
    // One access
    // ****************************************
    // The request stands one edge; released addr and din show inverted values, injects clear.
    task acc(input w, input [22:0] ad, input [71:0] d, input [1:0] inj,
        output [71:0] q, output [2:0] f);
        begin
            @(posedge mclk);
            en <= 1'b1;
            we <= w;
            addr <= ad;
            din <= d;
            mask <= 9'h1ff;
            {inj_d, inj_s} <= inj;
            @(posedge mclk);
            en <= 1'b0;
            addr <= ~ad;
            din <= ~d;
            {inj_d, inj_s} <= 2'h0;
            q = 72'h0;
            f = 3'h0;
            if (!w) begin
                @(posedge mclk);
                #1;
                q = dout;
                f = {rdacc, derr, serr};
            end
        end
    endtask
endmodule

// ===== verification/crbse_ram_tb.sv
// Self-checking bench for the chained ECC memory block.
`timescale 1ns/1ps
`include "crbse_ram_regs.vh"
module crbse_ram_tb;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg a_rst_n = 1'b0;
    reg b_rst_n = 1'b0;
    reg [255:0] noise = {8{32'h5a3c96e1}};
    integer miscompares = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    integer i;
    reg [63:0] d;
    reg [71:0] w, e, q, q2;
    reg [22:0] ad;
    reg [2:0] f, f2;
    wire [22:0] a_addr, b_addr;
    wire [71:0] a_din, b_din, a_dout, b_dout;
    wire [8:0] a_mask, b_mask;
    wire a_en, a_we, a_is, a_id, a_se, a_de, a_ra;
    wire b_en, b_we, b_is, b_id, b_se, b_de, b_ra;

    always #20 mclk = ~mclk;
    always @(posedge mclk) noise <= {noise[254:0], noise[255]};

    crbse_user ua (.mclk(mclk), .addr(a_addr), .en(a_en), .we(a_we),
        .din(a_din), .mask(a_mask), .inj_s(a_is), .inj_d(a_id),
        .dout(a_dout), .serr(a_se), .derr(a_de), .rdacc(a_ra));
    crbse_user ub (.mclk(mclk), .addr(b_addr), .en(b_en), .we(b_we),
        .din(b_din), .mask(b_mask), .inj_s(b_is), .inj_d(b_id),
        .dout(b_dout), .serr(b_se), .derr(b_de), .rdacc(b_ra));

    // Port A heads a two-block chain as block 1; port B decodes nothing.
    crbse_ram #(.CHAIN_ORDER_A(`CRBSE_ORDER_FIRST), .SELF_MASK_A(11'h7fe),
        .SELF_ADDR_A(11'h001), .ECC_DEC_B(0)) uut (
        .mclk(mclk), .rst_n(rst_n), .a_rst_n(a_rst_n), .b_rst_n(b_rst_n),
        .a_addr(a_addr), .a_en(a_en), .a_we(a_we), .a_din(a_din),
        .a_byte_write_mask(a_mask), .a_inject_single_error(a_is),
        .a_inject_double_error(a_id), .a_dout(a_dout),
        .a_single_error_flag(a_se), .a_double_error_flag(a_de),
        .a_rd_access(a_ra), .a_cas_in_addr(noise[22:0]),
        .a_cas_in_en(noise[23]), .a_cas_in_we(noise[24]),
        .a_cas_in_din(noise[96:25]), .a_cas_in_bwmask(noise[105:97]),
        .a_cas_in_inj_single(noise[106]), .a_cas_in_inj_double(noise[107]),
        .a_cas_in_dout(noise[179:108]), .a_cas_in_serr(noise[180]),
        .a_cas_in_derr(noise[181]), .a_cas_in_rdacc(noise[182]),
        .a_cas_out_addr(), .a_cas_out_en(), .a_cas_out_we(),
        .a_cas_out_din(), .a_cas_out_bwmask(), .a_cas_out_inj_single(),
        .a_cas_out_inj_double(), .a_cas_out_dout(), .a_cas_out_serr(),
        .a_cas_out_derr(), .a_cas_out_rdacc(),
        .b_addr(b_addr), .b_en(b_en), .b_we(b_we), .b_din(b_din),
        .b_byte_write_mask(b_mask), .b_inject_single_error(b_is),
        .b_inject_double_error(b_id), .b_dout(b_dout),
        .b_single_error_flag(b_se), .b_double_error_flag(b_de),
        .b_rd_access(b_ra), .b_cas_in_addr(noise[205:183]),
        .b_cas_in_en(noise[206]), .b_cas_in_we(noise[207]),
        .b_cas_in_din(noise[79:8]), .b_cas_in_bwmask(noise[216:208]),
        .b_cas_in_inj_single(noise[217]), .b_cas_in_inj_double(noise[218]),
        .b_cas_in_dout(noise[255:184]), .b_cas_in_serr(noise[219]),
        .b_cas_in_derr(noise[220]), .b_cas_in_rdacc(noise[221]),
        .b_cas_out_addr(), .b_cas_out_en(), .b_cas_out_we(),
        .b_cas_out_din(), .b_cas_out_bwmask(), .b_cas_out_inj_single(),
        .b_cas_out_inj_double(), .b_cas_out_dout(), .b_cas_out_serr(),
        .b_cas_out_derr(), .b_cas_out_rdacc());

    // ****************************************
    // Expectations and reporting
    // ****************************************
    // Encoded word: Hamming bits over positions 1..71, top bit overall parity.
    function [71:0] enc(input [63:0] v);
        integer p, k, j;
        reg [6:0] c;
        begin
            c = 7'h0;
            j = 0;
            for (p = 1; p < 72; p = p + 1) begin
                if ((p & (p - 1)) != 0) begin
                    for (k = 0; k < 7; k = k + 1) begin
                        c[k] = c[k] ^ (v[j] & p[k]);
                    end
                    j = j + 1;
                end
            end
            enc = {^{c, v}, c, v};
        end
    endfunction

    task check(input string name, input [74:0] seen, input [74:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task conclude;
        begin
            if (miscompares == 0 && cmp_count > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares = miscompares + 1;
            conclude;
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        a_rst_n <= 1'b1;
        b_rst_n <= 1'b1;
        d = 64'h0123456789abcdef;
        w = enc(d);
        ua.acc(1'b1, 23'h001003, {8'h5a, d}, 2'h0, q, f);
        ub.acc(1'b0, 23'h000003, 72'h0, 2'h0, q, f);
        check("b raw word", q, w);
        check("b flags", f, 3'h4);
        ua.acc(1'b0, 23'h001003, 72'h0, 2'h0, q, f);
        check("a read word", q, w);
        check("a flags", f, 3'h4);
        ua.acc(1'b1, 23'h000003, {8'h00, ~d}, 2'h0, q, f);
        ua.acc(1'b0, 23'h001003, 72'h0, 2'h0, q, f);
        check("miss write", q, w);
        ua.acc(1'b0, 23'h000003, 72'h0, 2'h0, q, f);
        check("miss read hold", q, w);
        check("miss read flags", f, 3'h0);
        for (i = 1; i < 4; i = i + 1) begin
            ad = {11'h001, 8'h01, i[3:0]};
            w = enc(d ^ i);
            e = w ^ {9'h0, (i > 1), 31'h0, 1'b1, 30'h0};
            ua.acc(1'b1, ad, {8'h00, d ^ i}, i[1:0], q, f);
            ub.acc(1'b0, ad, 72'h0, 2'h0, q, f);
            check("inject raw", q, e);
            ua.acc(1'b0, ad, 72'h0, 2'h0, q, f);
            check("inject dout", q, (i == 1) ? w : e);
            check("inject flags", f, (i == 1) ? 3'h5 : 3'h6);
            ub.acc(1'b0, ad, 72'h0, 2'h0, q, f);
            check("array kept", q, e);
        end
        ub.acc(1'b1, 23'h000030, {8'h00, d}, 2'h1, q, f);
        ua.acc(1'b0, 23'h001030, 72'h0, 2'h0, q, f);
        check("encoder only inject", q, enc(d));
        check("encoder only flags", f, 3'h5);
        fork
            ua.acc(1'b1, 23'h001005, {8'h00, ~d}, 2'h0, q2, f2);
            ub.acc(1'b0, 23'h000005, 72'h0, 2'h0, q, f);
        join
        check("same cycle", q, enc(~d));
        ua.acc(1'b0, 23'h001005, 72'h0, 2'h0, q, f);
        check("a same cycle", q, enc(~d));
        @(posedge mclk);
        a_rst_n <= 1'b0;
        @(posedge mclk);
        a_rst_n <= 1'b1;
        #1;
        check("port reset", {a_ra, a_de, a_se, a_dout}, 75'h0);
        ua.acc(1'b0, 23'h001003, 72'h0, 2'h0, q, f);
        check("read after reset", q, enc(d));
        conclude;
    end
endmodule
